// ### hdl/clock_source_defines.vh
// shared constants for the system clock source control block
// Overview of operation
// - supervisory core clock runs at half the system clock; others get it undivided
// - fll_select at 1 makes the loop, not the crystal, the system source, except at setting 111b
// - fll_select is always read/write and cleared only by power-on reset
// - power-on reset enables the amplifier; crystal_amp_disable at 1 turns it off
// - after amplifier enable, wait 250 ms, then set crystal_ready
// - crystal_mode 00 selects noise-immune mode, 01 selects quiet mode
// - crystal_mode 1x puts the oscillator in quiet mode on stop entry
// - crystal_mode 10 with amplifier on holds stop after wake until crystal_ready
// - crystal_mode 11 restarts after loop lock while the oscillator warms up
// - in quiet mode no warmup is needed and crystal_ready stays 1 while the amplifier is on
// - quiet to noise-immune change clears crystal_ready until warmup elapses again
// - loop output never exceeds 306 times the crystal frequency
// - loop locks within 64 crystal cycles after locking starts
// - fll_lock_enable starts locking; fll_locked is 1 only when running and locked
// - loop clock is divided per power_manage_enable and clock_divide_select
// - crystal used directly is power saving; otherwise the loop is the source
// - divide 1,2,4,8 without power management; 256, or crystal direct at 11
// - setting 111b switches the loop off unless switchback or processing core on
`ifndef CLOCK_SOURCE_DEFINES_VH
`define CLOCK_SOURCE_DEFINES_VH

// ----------------------------------------------------------------------------
// register map
// ----------------------------------------------------------------------------
`define PWR_CTRL_ADDR    12'h000
`define CLK_CTRL_ADDR    12'h004

// power control register fields
`define PWR_AMP_DIS_BIT  0
`define PWR_MODE_LSB     1
`define PWR_READY_BIT    3

// clock control register fields
`define CLK_FLL_SEL_BIT  0
`define CLK_LOCK_EN_BIT  1
`define CLK_LOCKED_BIT   2
`define CLK_POWER_MANAGE_ENABLE_BIT     3
`define CLK_DIV_LSB      4
`define CLK_SWB_BIT      6
`define CLK_SAVING_BIT   7
`define CLK_STOPPED_BIT  8
`define CLK_RUNNING_BIT  9

// reset values
`define AMP_DIS_RESET    1'b0
`define MODE_RESET       2'b00
`define FLL_SEL_RESET    1'b0
`define DIV_RESET        2'b00

// crystal modes
`define MODE_NOISE       2'b00
`define MODE_QUIET       2'b01
`define MODE_STOP_HOLD   2'b10
`define MODE_STOP_FAST   2'b11

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define CLK_HZ           20000000
`define WARMUP_MS        250
`define WARMUP_CYCLES    (`WARMUP_MS * (`CLK_HZ / 1000))
`define FLL_LOCK_XTAL    16'h0040
`define FLL_MULT         11'h132
`define PMM_DIV          9'h100

`endif

// ### hdl/clock_ratio_gen.v
// glitch-free divider and source switch producing both core clocks
`timescale 1ns/1ps
`default_nettype none
module clock_ratio_gen #(
  parameter CW = 9
) (
  // clock and reset
  input  wire          clk_i,
  input  wire          reset_i,
  // source ticks, one per source half period
  input  wire          fll_tick_i,
  input  wire          xtal_tick_i,
  input  wire          run_i,
  // requested setting
  input  wire          xtal_sel_i,
  input  wire [CW-1:0] ratio_i,
  // generated clocks and applied setting
  output reg           sys_clk_o,
  output reg           half_clk_o,
  output reg           applied_xtal_o
);

  localparam [CW-1:0] ONE = {{(CW-1){1'b0}}, 1'b1};

  reg  [CW-1:0] ratio;
  reg  [CW-1:0] count;
  wire          tick;
  wire          phase_end;

  assign tick      = run_i & (applied_xtal_o ? xtal_tick_i : fll_tick_i);
  assign phase_end = (count >= ratio - ONE);

  always @(posedge clk_i) begin
    if (reset_i) begin
      sys_clk_o      <= 1'b0;
      half_clk_o     <= 1'b0;
      applied_xtal_o <= 1'b1;
      ratio          <= ONE;
      count          <= {CW{1'b0}};
    end else if (tick) begin
      if (phase_end) begin
        count     <= {CW{1'b0}};
        sys_clk_o <= ~sys_clk_o;
        // half clock toggles on each system clock rise
        if (!sys_clk_o) begin
          half_clk_o <= ~half_clk_o;
        end
        // only switch when both clocks have just gone low, so the low
        // phase merely stretches and no pulse is ever cut short
        if (sys_clk_o && !half_clk_o) begin
          ratio          <= ratio_i;
          applied_xtal_o <= xtal_sel_i;
        end
      end else begin
        count <= count + ONE;
      end
    end
  end

endmodule // clock_ratio_gen
`default_nettype wire

// ### hdl/system_clock_source_control.v
// system clock source selection, crystal and loop control with apb registers
//
// The address map and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "clock_source_defines.vh"
module system_clock_source_control #(
  parameter        WARMUP_CYCLES = `WARMUP_CYCLES,
  parameter [15:0] LOCK_CYCLES   = `FLL_LOCK_XTAL,
  parameter [10:0] FLL_MULT      = `FLL_MULT
) (
  // clock and resets
  input  wire        clk_i,
  input  wire        reset_i,
  input  wire        soft_reset_i,
  // apb slave
  input  wire        psel_i,
  input  wire        penable_i,
  input  wire        pwrite_i,
  input  wire [11:0] paddr_i,
  input  wire [31:0] pwdata_i,
  output reg  [31:0] prdata_o,
  output reg         pready_o,
  output reg         pslverr_o,
  // crystal pin side
  input  wire        crystal_input_i,
  output reg         crystal_amp_enable_o,
  output reg         crystal_quiet_o,
  // stop mode and core status
  input  wire        stop_request_i,
  input  wire        wake_i,
  input  wire        processing_core_enable_i,
  // generated clocks and status
  output wire        sys_clk_o,
  output wire        supervisory_clk_o,
  output reg         fll_running_o,
  output reg         power_saving_o,
  output reg         stopped_o
);

  // --------------------------------------------------------------------------
  // states and helpers
  // --------------------------------------------------------------------------
  localparam [1:0] ST_RUN  = 2'd0;
  localparam [1:0] ST_STOP = 2'd1;
  localparam [1:0] ST_WAKE = 2'd2;

  localparam [31:0] WARM_DONE = WARMUP_CYCLES;

  function [8:0] div_ratio;
    input       power_manage_enable;
    input [1:0] cd;
    begin
      if (power_manage_enable) begin
        div_ratio = (cd == 2'b11) ? 9'h001 : `PMM_DIV;
      end else begin
        case (cd)
          2'b00:   div_ratio = 9'h001;
          2'b01:   div_ratio = 9'h002;
          2'b10:   div_ratio = 9'h004;
          default: div_ratio = 9'h008;
        endcase
      end
    end
  endfunction

  // --------------------------------------------------------------------------
  // pin synchronisers
  // --------------------------------------------------------------------------
  reg xtal_s1;
  reg xtal_s2;
  reg xtal_d;
  reg wake_s1;
  reg wake_s2;

  always @(posedge clk_i) begin
    if (reset_i) begin
      xtal_s1 <= 1'b0;
      xtal_s2 <= 1'b0;
      xtal_d  <= 1'b0;
      wake_s1 <= 1'b0;
      wake_s2 <= 1'b0;
    end else begin
      xtal_s1 <= crystal_input_i;
      xtal_s2 <= xtal_s1;
      xtal_d  <= xtal_s2;
      wake_s1 <= wake_i;
      wake_s2 <= wake_s1;
    end
  end

  wire xtal_rise = xtal_s2 & ~xtal_d;
  wire xtal_edge = xtal_s2 ^ xtal_d;

  // --------------------------------------------------------------------------
  // control registers
  // --------------------------------------------------------------------------
  reg       amp_dis;
  reg [1:0] xmode;
  reg       fll_sel;
  reg       lock_en;
  reg       power_manage_enable;
  reg [1:0] cdiv;
  reg       switchback_enable;
  reg [1:0] state;
  reg [1:0] next_state;

  wire any_reset = reset_i | soft_reset_i;
  wire setup     = psel_i & ~penable_i;
  wire hit_pwr   = (paddr_i == `PWR_CTRL_ADDR);
  wire hit_clk   = (paddr_i == `CLK_CTRL_ADDR);
  wire wr_en     = psel_i & penable_i & pready_o & pwrite_i;

  // power-domain bits survive every reset but power-on
  always @(posedge clk_i) begin
    if (reset_i) begin
      amp_dis <= `AMP_DIS_RESET;
      xmode   <= `MODE_RESET;
      fll_sel <= `FLL_SEL_RESET;
    end else begin
      if (wr_en && hit_pwr) begin
        amp_dis <= pwdata_i[`PWR_AMP_DIS_BIT];
        xmode   <= pwdata_i[`PWR_MODE_LSB+1:`PWR_MODE_LSB];
      end
      if (wr_en && hit_clk) begin
        fll_sel <= pwdata_i[`CLK_FLL_SEL_BIT];
      end
    end
  end

  always @(posedge clk_i) begin
    if (any_reset) begin
      lock_en <= 1'b0;
      power_manage_enable    <= 1'b0;
      cdiv    <= `DIV_RESET;
      switchback_enable     <= 1'b0;
    end else if (wr_en && hit_clk) begin
      lock_en <= pwdata_i[`CLK_LOCK_EN_BIT];
      power_manage_enable    <= pwdata_i[`CLK_POWER_MANAGE_ENABLE_BIT];
      cdiv    <= pwdata_i[`CLK_DIV_LSB+1:`CLK_DIV_LSB];
      switchback_enable     <= pwdata_i[`CLK_SWB_BIT];
    end
  end

  // --------------------------------------------------------------------------
  // crystal oscillator mode and warmup
  // --------------------------------------------------------------------------
  reg  [31:0] warm_cnt;
  wire        amp_on = ~amp_dis;
  // stop entry with mode 1x drops to quiet; wake leaves it at once
  wire        quiet  = (xmode == `MODE_QUIET) |
                       (xmode[1] & (state == ST_STOP));

  always @(posedge clk_i) begin
    if (reset_i) begin
      warm_cnt <= 32'h0000_0000;
    end else if (!amp_on || quiet) begin
      warm_cnt <= 32'h0000_0000;
    end else if (warm_cnt != WARM_DONE) begin
      warm_cnt <= warm_cnt + 32'h0000_0001;
    end
  end

  wire xtal_ready = amp_on & (quiet | (warm_cnt == WARM_DONE));

  // --------------------------------------------------------------------------
  // frequency-locked loop
  // --------------------------------------------------------------------------
  reg  [15:0] lock_cnt;
  reg  [10:0] per_cnt;
  wire        applied_xtal;
  wire        pmm2_req   = power_manage_enable & (cdiv == 2'b11);
  wire        xtal_req   = ~fll_sel | pmm2_req;
  // the loop is only released once the divider really runs from the
  // crystal, otherwise the switch point would never be reached
  wire        hf_off     = pmm2_req & applied_xtal & ~switchback_enable &
                           ~processing_core_enable_i;
  wire        next_fll_running = lock_en & (state != ST_STOP) & ~hf_off;
  wire        fll_locked = fll_running_o & (lock_cnt == LOCK_CYCLES);
  // half periods per crystal period are capped at twice the multiplier
  wire        fll_tick   = fll_running_o & (per_cnt < {FLL_MULT[9:0], 1'b0});

  always @(posedge clk_i) begin
    if (any_reset) begin
      fll_running_o <= 1'b0;
      lock_cnt      <= 16'h0000;
      per_cnt       <= 11'h000;
    end else begin
      fll_running_o <= next_fll_running;
      if (!fll_running_o) begin
        lock_cnt <= 16'h0000;
      end else if (xtal_rise && lock_cnt != LOCK_CYCLES) begin
        lock_cnt <= lock_cnt + 16'h0001;
      end
      if (xtal_rise) begin
        per_cnt <= 11'h000;
      end else if (fll_tick) begin
        per_cnt <= per_cnt + 11'h001;
      end
    end
  end

  // --------------------------------------------------------------------------
  // stop mode sequencing
  // --------------------------------------------------------------------------
  wire loop_ok  = xtal_req | ~lock_en | fll_locked;
  wire xtal_ok  = ~((xmode == `MODE_STOP_HOLD) & amp_on) | xtal_ready;

  always @* begin
    next_state = state;
    case (state)
      ST_RUN: begin
        if (stop_request_i) begin
          next_state = ST_STOP;
        end
      end
      ST_STOP: begin
        if (wake_s2) begin
          next_state = ST_WAKE;
        end
      end
      ST_WAKE: begin
        if (loop_ok && xtal_ok) begin
          next_state = ST_RUN;
        end
      end
      default: begin
        next_state = ST_RUN;
      end
    endcase
  end

  // reset ends stop mode and returns clocking to its defaults
  always @(posedge clk_i) begin
    if (any_reset) begin
      state <= ST_RUN;
    end else begin
      state <= next_state;
    end
  end

  // --------------------------------------------------------------------------
  // divider and clock outputs
  // --------------------------------------------------------------------------
  clock_ratio_gen #(
    .CW (9)
  ) u_ratio (
    .clk_i          (clk_i),
    .reset_i        (any_reset),
    .fll_tick_i     (fll_tick),
    .xtal_tick_i    (xtal_edge),
    .run_i          (state == ST_RUN),
    .xtal_sel_i     (xtal_req),
    .ratio_i        (xtal_req ? 9'h001 : div_ratio(power_manage_enable, cdiv)),
    .sys_clk_o      (sys_clk_o),
    .half_clk_o     (supervisory_clk_o),
    .applied_xtal_o (applied_xtal)
  );

  always @(posedge clk_i) begin
    if (reset_i) begin
      crystal_amp_enable_o <= 1'b0;
      crystal_quiet_o      <= 1'b0;
      power_saving_o       <= 1'b0;
      stopped_o            <= 1'b0;
    end else begin
      crystal_amp_enable_o <= amp_on;
      crystal_quiet_o      <= quiet;
      power_saving_o       <= applied_xtal;
      stopped_o            <= (state != ST_RUN);
    end
  end

  // --------------------------------------------------------------------------
  // apb read and response
  // --------------------------------------------------------------------------
  reg [31:0] rd_word;

  always @* begin
    rd_word = 32'h0000_0000;
    if (hit_pwr) begin
      rd_word[`PWR_AMP_DIS_BIT]                   = amp_dis;
      rd_word[`PWR_MODE_LSB+1:`PWR_MODE_LSB]      = xmode;
      rd_word[`PWR_READY_BIT]                     = xtal_ready;
    end else if (hit_clk) begin
      rd_word[`CLK_FLL_SEL_BIT]                   = fll_sel;
      rd_word[`CLK_LOCK_EN_BIT]                   = lock_en;
      rd_word[`CLK_LOCKED_BIT]                    = fll_locked;
      rd_word[`CLK_POWER_MANAGE_ENABLE_BIT]                      = power_manage_enable;
      rd_word[`CLK_DIV_LSB+1:`CLK_DIV_LSB]        = cdiv;
      rd_word[`CLK_SWB_BIT]                       = switchback_enable;
      rd_word[`CLK_SAVING_BIT]                    = applied_xtal;
      rd_word[`CLK_STOPPED_BIT]                   = (state != ST_RUN);
      rd_word[`CLK_RUNNING_BIT]                   = fll_running_o;
    end
  end

  // status is captured in the setup cycle so the answer comes with no wait
  always @(posedge clk_i) begin
    if (reset_i) begin
      prdata_o  <= 32'h0000_0000;
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      pready_o  <= setup;
      pslverr_o <= setup & ~(hit_pwr | hit_clk);
      if (setup) begin
        prdata_o <= pwrite_i ? 32'h0000_0000 : rd_word;
      end
    end
  end

endmodule // system_clock_source_control
`default_nettype wire

// ### verif/sccs_properties.sv
// port-level checks for the system clock source control block
`timescale 1ns/1ps
`default_nettype none
module sccs_properties (
  // clock and resets
  input wire logic        clk_i,
  input wire logic        reset_i,
  input wire logic        soft_reset_i,
  // apb
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  // crystal, stop and clocks
  input wire logic        crystal_amp_enable_o,
  input wire logic        crystal_quiet_o,
  input wire logic        stop_request_i,
  input wire logic        processing_core_enable_i,
  input wire logic        sys_clk_o,
  input wire logic        supervisory_clk_o,
  input wire logic        fll_running_o,
  input wire logic        stopped_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  sequence s_setup; psel_i && !penable_i; endsequence
  sequence s_acc; psel_i && penable_i && pready_o; endsequence
  sequence s_rd(a); s_acc ##0 (!pwrite_i && paddr_i == a); endsequence

  property p_answer; s_setup |=> pready_o ##1 !pready_o; endproperty
  property p_unmapped;
    s_acc ##0 (paddr_i != 12'h000 && paddr_i != 12'h004)
      |-> pslverr_o && prdata_o == 32'h0;
  endproperty
  // a soft reset may drop both clocks together, so that edge is skipped
  property p_half;
    $changed(supervisory_clk_o) && !$past(soft_reset_i) |-> $rose(sys_clk_o);
  endproperty
  property p_rise;
    $rose(sys_clk_o) && !$past(soft_reset_i) |-> $changed(supervisory_clk_o);
  endproperty
  property p_amp_off;
    s_acc ##0 (pwrite_i && paddr_i == 12'h000 && pwdata_i[0])
      |-> ##[1:2] !crystal_amp_enable_o;
  endproperty
  property p_stop;
    stop_request_i && !stopped_o && !soft_reset_i |-> ##[1:3] stopped_o;
  endproperty
  property p_lock_run; s_rd(12'h004) ##0 prdata_o[2] |-> fll_running_o;
  endproperty
  property p_quiet_ready;
    s_rd(12'h000) ##0 (crystal_quiet_o && $past(crystal_quiet_o)
      && crystal_amp_enable_o) |-> prdata_o[3];
  endproperty
  property p_saving_off;
    s_rd(12'h004) ##0 (prdata_o[7] && prdata_o[5:3] == 3'b111
      && !prdata_o[6] && !processing_core_enable_i
      && !$past(processing_core_enable_i)) |-> !fll_running_o;
  endproperty

  a_answer: assert property (p_answer)
    else $error("pready not a single pulse after setup");
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped access not refused");
  a_half: assert property (p_half)
    else $error("supervisory clock moved off a system rise");
  a_rise: assert property (p_rise)
    else $error("supervisory clock missed a system rise");
  a_amp_off: assert property (p_amp_off)
    else $error("amplifier still on after disable");
  a_stop: assert property (p_stop)
    else $error("stop request not taken");
  a_lock_run: assert property (p_lock_run)
    else $error("locked reported while loop stopped");
  a_quiet_ready: assert property (p_quiet_ready)
    else $error("ready low in quiet mode");
  a_saving_off: assert property (p_saving_off)
    else $error("loop running in crystal direct mode");
endmodule // sccs_properties
`default_nettype wire

// ### verif/crystal_model.sv
// behavioural crystal of about 495 khz (2020 ns period) that only oscillates while amplified
`timescale 1ns/1ps
`default_nettype none
module crystal_model #(
  parameter real HALF_NS = 1010.0
) (
  input  wire logic amp_enable_i,
  output var  logic crystal_o
);
  // the 1 ns offset keeps every crystal edge off both clock edges
  initial begin
    crystal_o = 1'b0;
    #1;
    forever begin
      #(HALF_NS);
      crystal_o = amp_enable_i ? !crystal_o : 1'b0;
    end
  end
endmodule // crystal_model
`default_nettype wire

// ### verif/tb_system_clock_source_control.sv
// self-checking bench for the system clock source control block
`timescale 1ns/1ps
`default_nettype none
module tb_system_clock_source_control;
  localparam int WARM = 400;
  logic        clk_i = 1'b0;
  logic        reset_i = 1'b1;
  logic        soft_reset_i = 1'b0;
  logic        psel_i = 1'b0;
  logic        penable_i = 1'b0;
  logic        pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0;
  logic        stop_request_i = 1'b0;
  logic        wake_i = 1'b0;
  logic        processing_core_enable_i = 1'b0;
  wire  [31:0] prdata_o;
  wire         pready_o, pslverr_o, crystal_input_i, crystal_amp_enable_o;
  wire         crystal_quiet_o, sys_clk_o, supervisory_clk_o;
  wire         fll_running_o, power_saving_o, stopped_o;
  int          bad_count = 0;
  int          checked = 0;
  int          n;
  logic [31:0] q;
  logic        err;

  system_clock_source_control #(.WARMUP_CYCLES(WARM), .LOCK_CYCLES(16'd4))
    DUT (.clk_i, .reset_i, .soft_reset_i, .psel_i, .penable_i, .pwrite_i,
    .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .crystal_input_i,
    .crystal_amp_enable_o, .crystal_quiet_o, .stop_request_i, .wake_i,
    .processing_core_enable_i, .sys_clk_o, .supervisory_clk_o,
    .fll_running_o, .power_saving_o, .stopped_o);
  crystal_model xtal (.amp_enable_i(crystal_amp_enable_o),
    .crystal_o(crystal_input_i));

  always #25 clk_i = !clk_i;

  task automatic chk(input string what, input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one apb transfer; two idle cycles let registered outputs settle
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do @(posedge clk_i); while (pready_o !== 1'b1);
    q = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e,
                    input string what);
    apb(1'b0, a, 32'h0);
    chk(what, q, e);
  endtask
  // cycles between two rises of the system or supervisory clock
  task automatic per(input bit sup, output int p);
    logic last;
    logic cur;
    int k;
    int g;
    k = 0;
    g = 0;
    p = 0;
    last = sup ? supervisory_clk_o : sys_clk_o;
    while (k < 2 && g < 5000) begin
      @(posedge clk_i);
      #1;
      cur = sup ? supervisory_clk_o : sys_clk_o;
      if (cur && !last) k++;
      if (k == 1) p++;
      last = cur;
      g++;
    end
  endtask
  task automatic stop_wake(input logic [31:0] mode);
    int g;
    g = 0;
    wr(12'h000, mode);
    stop_request_i <= 1'b1;
    @(posedge clk_i);
    stop_request_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    chk("quiet in stop", crystal_quiet_o, 32'h1);
    wake_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    wake_i <= 1'b0;
    if (mode == 32'h4) begin
      repeat (300) @(posedge clk_i);
      chk("held for warmup", stopped_o, 32'h1);
    end
    while (stopped_o !== 1'b0 && g < 2000) begin
      @(posedge clk_i);
      g++;
    end
  endtask
  task automatic wrap_up();
    $display("checked %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
    rd(12'h000, 32'h0, "power control");
    rd(12'h004, 32'h80, "clock control");
    chk("amp on", crystal_amp_enable_o, 32'h1);
    repeat (WARM + 20) @(posedge clk_i);
    rd(12'h000, 32'h8, "ready after warmup");
    wr(12'h000, 32'h2);
    chk("quiet", crystal_quiet_o, 32'h1);
    rd(12'h000, 32'ha, "quiet ready");
    wr(12'h000, 32'h0);
    chk("noise immune", crystal_quiet_o, 32'h0);
    rd(12'h000, 32'h0, "ready cleared");
    repeat (WARM + 20) @(posedge clk_i);
    rd(12'h000, 32'h8, "ready again");
    wr(12'h000, 32'h1);
    chk("amp off", crystal_amp_enable_o, 32'h0);
    wr(12'h000, 32'h0);
    rd(12'h008, 32'h0, "unmapped data");
    chk("unmapped error", err, 32'h1);
    repeat (100) @(posedge clk_i);
    per(1'b0, n);
    chk("crystal direct", n inside {40, 41}, 32'h1);
    wr(12'h004, 32'h2);
    rd(12'h004, 32'h282, "unlocked");
    repeat (300) @(posedge clk_i);
    rd(12'h004, 32'h286, "locked");
    for (int i = 0; i < 8; i++) begin
      wr(12'h004, 32'h3 | ((i % 4) << 4) | ((i / 4) << 3));
      repeat (1100) @(posedge clk_i);
      per(1'b0, n);
      if (i == 7) chk("crystal period", n inside {40, 41}, 32'h1);
      else chk("sys period", n, (i < 4) ? (2 << i) : 512);
      per(1'b1, n);
      if (i < 7) chk("half period", n, (i < 4) ? (4 << i) : 1024);
    end
    chk("saving", power_saving_o, 32'h1);
    rd(12'h004, 32'hbb, "loop off");
    processing_core_enable_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    chk("loop for core", fll_running_o, 32'h1);
    processing_core_enable_i <= 1'b0;
    wr(12'h004, 32'h7b);
    chk("loop for switchback", fll_running_o, 32'h1);
    soft_reset_i <= 1'b1;
    @(posedge clk_i);
    soft_reset_i <= 1'b0;
    @(posedge clk_i);
    rd(12'h004, 32'h81, "after soft reset");
    wr(12'h004, 32'h3);
    repeat (300) @(posedge clk_i);
    stop_wake(32'h4);
    rd(12'h000, 32'hc, "ready at restart");
    stop_wake(32'h6);
    rd(12'h000, 32'h6, "restart before ready");
    chk("running", stopped_o, 32'h0);
    wrap_up();
  end

  initial begin
    #3000000;
    bad_count++;
    wrap_up();
  end
endmodule // tb_system_clock_source_control

bind system_clock_source_control sccs_properties chk_props (.clk_i,
  .reset_i, .soft_reset_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
  .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .crystal_amp_enable_o,
  .crystal_quiet_o, .stop_request_i, .processing_core_enable_i, .sys_clk_o,
  .supervisory_clk_o, .fll_running_o, .stopped_o);
`default_nettype wire
